// [src/stcp_pkg.sv]
// Package of register offsets, field positions and codes for the timer
// What this block does
// RULE1: Counter readable as low byte, high byte bits 1:0
// RULE2: High-byte bits 7 to 2 read zero
// RULE3: Compare-A value read/write as two bytes, resets zero
// RULE4: Four modes chosen by two-bit mode field; capture mode 01 is not built and only counts, clearing on P match
// RULE5: Mode 00 is compare-match output mode
// RULE6: Clear-select low: clear on P match or overflow
// RULE7: Clear-select high: clear on A match, no P flag
// RULE8: Software never sets compare-A zero in compare mode
// RULE9: Compare mode pin changes only on A match
// RULE10: Pin action high, low or toggle on A match
// RULE11: Initial pin level from initial-level bit at start
// RULE12: Counter-on rising edge restores pin initial state
// RULE13: Mode 11 counts like compare, pin not driven
// RULE14: Software sets mode 10 and pin action 10 for PWM
// RULE15: PWM uses one compare for period, other duty
// RULE16: Swap bit zero: compare-P match clears counter
// RULE17: PWM sets A flag and P flag on matches
// RULE18: PWM active level, force levels, invert bit
// RULE19: PWM counting continues while output is forced
// RULE20: Period comparator clear starts a new PWM period
// RULE21: Pin action 00 none, 01 low, 10 high, 11 toggle
// RULE22: Compare-P matches counter bits 9:7, zero means overflow
// RULE23: Counter-on rise zeroes counter, fall holds count
// RULE24: Swap bit selects which compare sets period
// RULE25: Counter increments per tick, wraps 1023 to zero
package stcp_pkg;
    localparam int CNT_W = 10;
    localparam int CP_W  = 3;
    // Byte addresses of the APB registers
    localparam logic [7:0] ADDR_CNT_LO  = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI  = 8'h04;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h08;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h0c;
    localparam logic [7:0] ADDR_CTRL0   = 8'h10;
    localparam logic [7:0] ADDR_CTRL1   = 8'h14;
    localparam logic [7:0] ADDR_FLAGS   = 8'h18;
    // Control zero fields
    localparam int C0_ON  = 3;
    localparam int C0_CP  = 0;
    // Control one fields
    localparam int C1_MODE = 6;
    localparam int C1_PA   = 4;
    localparam int C1_OC   = 3;
    localparam int C1_INV  = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CCLR = 0;
    // Flag bits
    localparam int FL_A = 0;
    localparam int FL_P = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [9:0] CNT_ONE    = 10'h001;
    localparam logic [9:0] CNT_ZERO   = 10'h000;
    localparam logic [2:0] CP_ZERO    = 3'h0;
    localparam logic [9:0] CNT_MAX    = 10'h3ff;
    typedef enum logic [1:0] {
        STCP_MODE_CMP, STCP_MODE_CAP, STCP_MODE_PWM, STCP_MODE_TMR
    } stcp_mode_e;
    typedef enum logic [1:0] {
        STCP_PA_NONE, STCP_PA_LOW, STCP_PA_HIGH, STCP_PA_TOGGLE
    } stcp_pa_e;
endpackage : stcp_pkg

// [src/stcp_apb_regs.sv]
// APB slave holding the control, compare-A and flag registers
`timescale 1ns/1ns
module stcp_apb_regs
    import stcp_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    // APB
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Timer state seen by software
    input  wire logic [stcp_pkg::CNT_W-1:0] count_value,
    input  wire logic                 set_flag_a,
    input  wire logic                 set_flag_p,
    // Settings to the timer core
    output logic      [7:0]           ctrl0,
    output logic      [7:0]           ctrl1,
    output logic      [stcp_pkg::CNT_W-1:0] cmpa
);
    import stcp_pkg::*;

    typedef struct packed {
        logic [7:0]       ctrl0;
        logic [7:0]       ctrl1;
        logic [CNT_W-1:0] cmpa;
        logic             fa;
        logic             fp;
        logic [31:0]      rdata;
    } stcp_regs_s;

    stcp_regs_s st_reg;
    stcp_regs_s st_next;
    logic       wr;

    assign wr = psel && penable && pwrite;

    // Decode, write and flag update; a hardware set beats a software clear
    always_comb begin
        st_next = st_reg;
        if (wr) begin
            if (paddr == ADDR_CMPA_LO) begin
                st_next.cmpa[7:0] = pwdata[7:0];  // [RULE3]
            end else if (paddr == ADDR_CMPA_HI) begin
                st_next.cmpa[9:8] = pwdata[1:0];  // [RULE3]
            end else if (paddr == ADDR_CTRL0) begin
                st_next.ctrl0 = pwdata[7:0];
            end else if (paddr == ADDR_CTRL1) begin
                st_next.ctrl1 = pwdata[7:0];
            end else if (paddr == ADDR_FLAGS) begin
                // Write one to clear
                if (pwdata[FL_A]) st_next.fa = 1'b0;
                if (pwdata[FL_P]) st_next.fp = 1'b0;
            end
            // Counter bytes are read-only, so writes there are dropped
        end
        if (set_flag_a) st_next.fa = 1'b1;
        if (set_flag_p) st_next.fp = 1'b1;
        // Read data captured one cycle before the access edge
        st_next.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_CNT_LO) begin
                st_next.rdata[7:0] = count_value[7:0];  // [RULE1]
            end else if (paddr == ADDR_CNT_HI) begin
                st_next.rdata[1:0] = count_value[9:8];  // [RULE1] [RULE2]
            end else if (paddr == ADDR_CMPA_LO) begin
                st_next.rdata[7:0] = st_reg.cmpa[7:0];
            end else if (paddr == ADDR_CMPA_HI) begin
                st_next.rdata[1:0] = st_reg.cmpa[9:8];  // [RULE2]
            end else if (paddr == ADDR_CTRL0) begin
                st_next.rdata[7:0] = st_reg.ctrl0;
            end else if (paddr == ADDR_CTRL1) begin
                st_next.rdata[7:0] = st_reg.ctrl1;
            end else if (paddr == ADDR_FLAGS) begin
                st_next.rdata[FL_A] = st_reg.fa;
                st_next.rdata[FL_P] = st_reg.fp;
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign pslverr = psel && penable &&
        !(paddr == ADDR_CNT_LO || paddr == ADDR_CNT_HI ||
          paddr == ADDR_CMPA_LO || paddr == ADDR_CMPA_HI ||
          paddr == ADDR_CTRL0 || paddr == ADDR_CTRL1 ||
          paddr == ADDR_FLAGS);
    assign ctrl0   = st_reg.ctrl0;
    assign ctrl1   = st_reg.ctrl1;
    assign cmpa    = st_reg.cmpa;
endmodule : stcp_apb_regs

// [src/stcp_pin_sync.sv]
// Three-stage synchroniser for the external timer clock tick
`timescale 1ns/1ns
module stcp_pin_sync
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Asynchronous input and its settled rising edge
    input  wire logic pin_in,
    output logic      rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } stcp_sync_s;

    stcp_sync_s st_reg;
    stcp_sync_s st_next;

    // A change counts only once stages two and three agree
    always_comb begin
        st_next      = st_reg;
        st_next.s1   = pin_in;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        st_next.rise = 1'b0;
        if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.lvl) begin
            st_next.lvl  = st_reg.s3;
            st_next.rise = st_reg.s3;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise = st_reg.rise;
endmodule : stcp_pin_sync

// [src/stcp_timer.sv]
// Ten-bit standard timer with compare, timer/counter and PWM modes
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module stcp_timer
    import stcp_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Selected timer clock, asynchronous
    input  wire logic        timer_tick,
    // Timer output pin
    output logic             timer_output_pin,
    output logic             timer_output_pin_oe,
    // Match flags as pulses for observation
    output logic             match_a_flag,
    output logic             match_p_flag
);
    import stcp_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             on_d;
        logic             pin;
        logic             ev_a;
        logic             ev_p;
        logic             out;
        logic             oe;
    } stcp_core_s;

    stcp_core_s       st_reg;
    stcp_core_s       st_next;
    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [CNT_W-1:0] cmpa;
    logic             tick;
    logic             counter_on;
    logic [1:0]       mode_sel;
    logic [1:0]       pin_act;
    logic             out_init;
    logic             out_inv;
    logic             swap;
    logic             clr_sel;
    logic [CP_W-1:0]  cmpp;
    logic [CNT_W-1:0] nxt;
    logic             hit_a;
    logic             hit_p;
    logic             wrap;
    logic             clr;
    logic             fa;
    logic             fp;
    logic             duty_act;
    logic [CNT_W-1:0] per_end;

    // Compare-P match: top three bits against the three-bit value
    function automatic logic p_match(input logic [CNT_W-1:0] c,
                                     input logic [CP_W-1:0] p);
        p_match = (p != CP_ZERO) &&
                  (c[CNT_W-1:CNT_W-CP_W] == p);  // [RULE22]
    endfunction : p_match

    stcp_apb_regs u_regs (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .count_value (st_reg.cnt),
        .set_flag_a  (st_reg.ev_a),
        .set_flag_p  (st_reg.ev_p),
        .ctrl0       (ctrl0),
        .ctrl1       (ctrl1),
        .cmpa        (cmpa)
    );

    stcp_pin_sync u_tick (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pin_in  (timer_tick),
        .rise    (tick)
    );

    // Field extraction from the two control registers
    assign counter_on = ctrl0[C0_ON];
    assign cmpp       = ctrl0[C0_CP+:CP_W];
    assign mode_sel   = ctrl1[C1_MODE+:2];  // [RULE4]
    assign pin_act    = ctrl1[C1_PA+:2];
    assign out_init   = ctrl1[C1_OC];
    assign out_inv    = ctrl1[C1_INV];
    assign swap       = ctrl1[C1_SWAP];
    assign clr_sel    = ctrl1[C1_CCLR];

    // Match detection on the count reached at this tick
    assign nxt   = st_reg.cnt + CNT_ONE;  // [RULE25]
    assign hit_a = (nxt == cmpa);
    assign hit_p = p_match(nxt, cmpp);
    assign wrap  = (st_reg.cnt == CNT_MAX);

    // Clearing and flag choice per mode
    always_comb begin
        clr = 1'b0;
        fa  = 1'b0;
        fp  = 1'b0;
        case (mode_sel)
            STCP_MODE_PWM: begin
                // Clear-select ignored here; swap picks the period source
                fa = hit_a;  // [RULE17]
                fp = hit_p || (cmpp == CP_ZERO && wrap);  // [RULE17]
                clr = swap ? hit_a : hit_p;  // [RULE15] [RULE16] [RULE24]
            end
            STCP_MODE_CMP, STCP_MODE_TMR: begin
                // Timer/counter counts and flags just as compare mode
                if (clr_sel) begin
                    fa  = hit_a;  // [RULE7]
                    clr = hit_a;  // [RULE7]
                end else begin
                    fa  = hit_a;  // [RULE6]
                    fp  = hit_p || (cmpp == CP_ZERO && wrap);  // [RULE6]
                    clr = hit_p;  // [RULE5] [RULE6] [RULE13]
                end
            end
            default: begin
                // Capture mode is not built; the counter clears on P match and sets no flags
                clr = hit_p;
            end
        endcase
    end

    // PWM duty is active while the count is below the duty compare
    always_comb begin
        per_end  = {cmpp, 7'h00};
        duty_act = swap ? (st_reg.cnt < per_end || cmpp == CP_ZERO)
                        : (st_reg.cnt < cmpa);  // [RULE24]
    end

    // Counter, pin state and events
    always_comb begin
        st_next      = st_reg;
        st_next.on_d = counter_on;
        st_next.ev_a = 1'b0;
        st_next.ev_p = 1'b0;
        if (counter_on && !st_reg.on_d) begin
            // Restart: zero count, restore initial pin level
            st_next.cnt = CNT_ZERO;  // [RULE23]
            st_next.pin = out_init;  // [RULE11] [RULE12]
        end else if (counter_on && tick) begin
            // Period comparator clear begins a new PWM period
            st_next.cnt  = clr ? CNT_ZERO : nxt;  // [RULE20] [RULE25]
            st_next.ev_a = fa;
            st_next.ev_p = fp;
            // Pin moves on A match only; P matches never touch it
            if (mode_sel == STCP_MODE_CMP && fa) begin  // [RULE9]
                case (pin_act)
                    STCP_PA_LOW:    st_next.pin = 1'b0;  // [RULE10] [RULE21]
                    STCP_PA_HIGH:   st_next.pin = 1'b1;  // [RULE10] [RULE21]
                    STCP_PA_TOGGLE: st_next.pin = !st_reg.pin;  // [RULE21]
                    default:        st_next.pin = st_reg.pin;  // [RULE10]
                endcase
            end
        end
        // Output stage; counter off holds residual count (RULE23 hold)
        case (mode_sel)
            STCP_MODE_CMP: begin
                st_next.out = st_next.pin ^ out_inv;
                st_next.oe  = 1'b1;
            end
            STCP_MODE_PWM: begin
                // Forced levels keep counting running underneath
                case (pin_act)
                    STCP_PA_NONE:
                        st_next.out = (!out_init) ^ out_inv;  // [RULE19]
                    STCP_PA_LOW:
                        st_next.out = out_init ^ out_inv;  // [RULE19]
                    default:
                        st_next.out = (duty_act ? out_init : !out_init)
                                      ^ out_inv;  // [RULE18]
                endcase
                st_next.oe = 1'b1;
            end
            default: begin
                // Pin left free for its other functions
                st_next.out = 1'b0;  // [RULE13]
                st_next.oe  = 1'b0;  // [RULE13]
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign timer_output_pin    = st_reg.out;
    assign timer_output_pin_oe = st_reg.oe;
    assign match_a_flag        = st_reg.ev_a;
    assign match_p_flag        = st_reg.ev_p;
endmodule : stcp_timer

// [verif/stcp_timer_props.sv]
// Port-level assertions for the ten-bit compare/PWM timer
`timescale 1ns/1ns
module stcp_timer_props
    import stcp_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer side
    input wire logic        timer_tick,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_pin_oe,
    input wire logic        match_a_flag,
    input wire logic        match_p_flag
);
    logic [7:0] c0_reg;
    logic [7:0] c1_reg;
    logic [1:0] calm_reg;
    logic       acc;
    logic       wr_c0;
    logic       wr_c1;
    logic       calm;
    logic       rd_hi;
    assign acc = psel && penable;
    assign wr_c0 = acc && pwrite && paddr == ADDR_CTRL0;
    assign wr_c1 = acc && pwrite && paddr == ADDR_CTRL1;
    assign rd_hi = acc && !pwrite &&
        (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI);
    assign calm = calm_reg == 2'd3;
    // Shadow control bytes; calm waits out the pin pipeline after a write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            c0_reg <= 8'h00;
            c1_reg <= 8'h00;
            calm_reg <= 2'd0;
        end else begin
            if (wr_c0) c0_reg <= pwdata[7:0];
            if (wr_c1) c1_reg <= pwdata[7:0];
            if (wr_c0 || wr_c1) calm_reg <= 2'd0;
            else if (!calm) calm_reg <= calm_reg + 2'd1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    hi_bits_zero_a: assert property (
        rd_hi |-> prdata[31:2] == 30'h0)
        else $error("high byte upper bits not zero");
    restart_level_a: assert property (
        wr_c0 && pwdata[C0_ON] && !c0_reg[C0_ON] && c1_reg[7:6] == 2'b00
        |-> ##[1:3] timer_output_pin == (c1_reg[C1_OC] ^ c1_reg[C1_INV]))
        else $error("pin not at initial level after restart");
    pin_free_a: assert property (
        calm && c1_reg[7:6] == 2'b11 |-> !timer_output_pin_oe)
        else $error("pin driven in timer mode");
    pin_drive_a: assert property (
        calm && !c1_reg[6] |-> timer_output_pin_oe)
        else $error("pin not driven in output mode");
    no_p_flag_a: assert property (
        calm && c1_reg[7:6] == 2'b00 && c1_reg[C1_CCLR] |-> !match_p_flag)
        else $error("P flag raised with clear on A");
    a_only_pin_a: assert property (
        calm && c1_reg[7:6] == 2'b00 && !match_a_flag
        && !$past(match_a_flag) && !$past(match_a_flag, 2)
        |-> $stable(timer_output_pin))
        else $error("pin moved without A match");
    forced_pwm_a: assert property (
        calm && c1_reg[7:5] == 3'b100 && !c1_reg[C1_INV]
        |-> timer_output_pin == (c1_reg[4] ~^ c1_reg[C1_OC]))
        else $error("forced PWM level wrong");
    unmapped_err_a: assert property (
        acc |-> pslverr == (paddr > ADDR_FLAGS || paddr[1:0] != 2'b00))
        else $error("error response wrong");
    cover property (wr_c0 && pwdata[C0_ON]);
    cover property (match_p_flag);
    cover property (acc && pslverr);
endmodule : stcp_timer_props

bind stcp_timer stcp_timer_props stcp_timer_props_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
    .timer_output_pin(timer_output_pin),
    .timer_output_pin_oe(timer_output_pin_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
);

// [verif/stcp_timer_bench.sv]
// Self-checking bench for the ten-bit compare/PWM timer
`timescale 1ns/1ns
module stcp_timer_bench;
    import stcp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        timer_tick = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, timer_output_pin, timer_output_pin_oe;
    logic        match_a_flag, match_p_flag;
    logic [31:0] seed = 32'h9f35;
    logic [31:0] rdat;
    logic        err;
    logic [7:0]  c1s [5] = '{8'ha9, 8'had, 8'h89, 8'h99, 8'hab};
    int          hs [5] = '{32, 96, 0, 128, 100};
    int          n_mismatch = 0, n_compared = 0, cyc = 0;
    int          na = 0, np = 0, a0, p0, hi, n, v, e1;
    int          mc = 0, mper = 1024, mcmpa = 0;

    always #10 sys_clk = ~sys_clk;

    stcp_timer stcp_timer_i (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
        .timer_output_pin(timer_output_pin),
        .timer_output_pin_oe(timer_output_pin_oe),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
    );

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // Flag pulse totals; the ceiling cuts a hung run short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (match_a_flag === 1'b1) na <= na + 1;
        if (match_p_flag === 1'b1) np <= np + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    // Upper bits carry random junk that the register must drop
    task setcmpa(input int val);
        apb(1'b1, ADDR_CMPA_LO, (rnd() & 32'hffffff00) | (val & 255));
        apb(1'b1, ADDR_CMPA_HI, (rnd() & 32'hfffffffc) | (val >> 8));
        mcmpa = val;
    endtask : setcmpa

    // Slow ticks give the synchroniser room; pin sampled per count
    task run(input int k);
        repeat (k) begin
            timer_tick <= 1'b1;
            repeat (4) @(posedge sys_clk);
            timer_tick <= 1'b0;
            repeat (4) @(posedge sys_clk);
            hi += (timer_output_pin === 1'b1);
            mc = (mc + 1) % mper;  // Model count, cleared at period end
        end
    endtask : run

    task start(input logic [7:0] c1, input logic [2:0] cp);
        apb(1'b1, ADDR_CTRL0, 32'h0);
        apb(1'b1, ADDR_CTRL1, {24'h0, c1});
        apb(1'b1, ADDR_CTRL0, 32'h8 | cp);
        repeat (3) @(posedge sys_clk);
        a0 = na;
        p0 = np;
        hi = 0;
        // Model period: the clearing compare, or overflow at 1024
        mc = 0;
        mper = (cp == 3'h0) ? 1024 : cp * 128;
        if ((c1[7:6] == 2'b10) ? c1[1] : c1[0]) mper = mcmpa;
    endtask : start

    // Both counter bytes against the model count
    task cnt_chk;
        rd(ADDR_CNT_LO, mc & 255);
        rd(ADDR_CNT_HI, mc >> 8);
    endtask : cnt_chk

    task flags(input int ea, input int ep);
        chk(na - a0, ea);
        chk(np - p0, ep);
    endtask : flags

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd(i * 4, 0);
        v = rnd() % 1024;
        setcmpa(v);
        rd(ADDR_CMPA_LO, v & 255);
        rd(ADDR_CMPA_HI, v >> 8);
        apb(1'b1, ADDR_CNT_LO, rnd());
        rd(ADDR_CNT_LO, 0);
        rd(8'h1c, 0);
        chk({31'h0, err}, 1);
        $display("test registers done");
        n = 2 + rnd() % 6;
        setcmpa(n);
        for (int i = 0; i < 8; i++) begin
            start(8'h01 | (i << 3), 3'h0);
            e1 = i & 1;
            chk({31'h0, timer_output_pin}, e1);
            run(n);
            if (i / 2 == 1) e1 = 0;
            else if (i / 2 == 2) e1 = 1;
            else if (i / 2 == 3) e1 = 1 - e1;
            chk({31'h0, timer_output_pin}, e1);
            run(n + 1);
            if (i / 2 == 3) e1 = 1 - e1;
            chk({31'h0, timer_output_pin}, e1);
            cnt_chk();
            flags(2, 0);
        end
        $display("test compare clear on A done");
        setcmpa(40);
        for (int i = 0; i < 4; i++) begin
            start((i & 1) ? 8'hf0 : 8'h30, (i < 2) ? 3'h1 : 3'h0);
            run((i < 2) ? 130 : 1026);
            cnt_chk();
            flags(1, 1);
            chk({31'h0, timer_output_pin_oe}, 1 - (i & 1));
            if (!(i & 1)) chk({31'h0, timer_output_pin}, 1);
        end
        $display("test compare clear on P done");
        // Counter off: ticks must leave the residual count alone
        apb(1'b1, ADDR_CTRL0, 32'h0);
        v = mc;
        run(3);
        mc = v;
        cnt_chk();
        // Clear on A with compare-P below compare-A: no P flag
        setcmpa(200);
        start(8'h01, 3'h1);
        run(200);
        cnt_chk();
        flags(1, 0);
        // Sticky flags read back, then cleared by writing ones
        rd(ADDR_FLAGS, 3);
        apb(1'b1, ADDR_FLAGS, 3);
        rd(ADDR_FLAGS, 0);
        $display("test hold and flags done");
        for (int i = 0; i < 5; i++) begin
            setcmpa((i < 4) ? 32 : 100);
            start(c1s[i], 3'h1);
            run((i < 4) ? 128 : 100);
            chk(hi, hs[i]);
            cnt_chk();
            flags(1, (i < 4) ? 1 : 0);
        end
        $display("test pwm done");
        report_and_stop();
    end
endmodule : stcp_timer_bench
